// ==== rtl/cmc_pkg.sv ====
// Constants shared by the clock monitor control block and its helpers.
package cmc_pkg;

	// ==================================================
	// Register port
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STAGE = 4'h1;
	localparam logic [3:0] OFS_DIVIDER = 4'h2;
	localparam logic [3:0] OFS_STEP = 4'h3;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_MASK = 4'h5;
	localparam logic [3:0] OFS_CONFIG = 4'h6;
	localparam logic [7:0] RD_NONE = 8'h00;

	// ==================================================
	// Generator control register fields
	localparam int B_IRQ_EN = 7;
	localparam int B_FLAG = 6;
	localparam int B_MON_EN = 5;
	localparam int B_CSEL = 4;
	localparam int B_EXT_ON = 3;
	localparam int B_EXT_STAB = 2;
	localparam int B_INT_ON = 1;
	localparam int B_INT_STAB = 0;

	// ==================================================
	// Step, status and config fields
	localparam int B_STEP_UP = 0;
	localparam int B_STEP_DN = 1;
	localparam int B_SLOW_EXT = 0;
	localparam int ST_W = 4;
	localparam int ST_TRIP = 0;
	localparam int ST_FORCED = 1;
	localparam int ST_STAB_LOST = 2;
	localparam int ST_LIMIT = 3;

	// ==================================================
	// Reset values
	localparam logic RST_INT_ON = 1'b1;
	localparam logic RST_EXT_ON = 1'b0;
	localparam logic [7:0] RST_STAGE = 8'h80;
	localparam logic [3:0] RST_DIV = 4'h0;
	localparam logic [3:0] RST_MASK = 4'h0;

	// ==================================================
	// Oscillator and switch timing
	localparam logic [3:0] DIV_MAX = 4'h9;
	localparam logic [7:0] STAGE_TOP = 8'hFF;
	localparam logic [7:0] STAGE_BOT = 8'h00;
	localparam logic [5:0] RING_MIN = 6'h11;
	localparam logic [5:0] RING_FINE = 6'h02;
	localparam logic [5:0] RING_DOUBLED = 6'h22;
	localparam logic [2:0] COARSE_TOP = 3'h7;
	localparam logic [1:0] SW_HOLD_LAST = 2'h1;

	// Glitch free switch phases.
	typedef enum logic {SW_RUN, SW_HOLD} cmc_sw_t;

endpackage : cmc_pkg

// ==== rtl/cmc_sync3.sv ====
// Three stage synchroniser for asynchronous status levels.
`timescale 1ns/1ps

module cmc_sync3 #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Levels
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout_q
);

	logic [W-1:0] ff1_q;
	logic [W-1:0] ff2_q;
	logic [W-1:0] ff3_q;

	// Shift chain; the first stage feeds only the second.
	always_ff @(posedge mclk) begin
		ff1_q <= din;
		ff2_q <= ff1_q;
		ff3_q <= ff2_q;
	end

	// A change is accepted once the second and third stages agree.
	always_ff @(posedge mclk) begin
		if (reset) begin
			dout_q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (ff2_q[i] == ff3_q[i]) begin
					dout_q[i] <= ff3_q[i];
				end
			end
		end
	end

endmodule : cmc_sync3

// ==== rtl/cmc_dco.sv ====
// Loop filter output stepping and oscillator period selection.
`timescale 1ns/1ps

module cmc_dco
	import cmc_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Single step requests
	input wire logic step_up,
	input wire logic step_down,
	// Oscillator controls
	output logic [7:0] stage_control_q,
	output logic [3:0] divider_control_q,
	output logic [5:0] ring_stages_q,
	output logic limit_q
);

	logic [4:0] phase_q;
	logic long_ring;
	logic [5:0] coarse;

	// Moves the twelve bit control by exactly one; the top bit flags a limit.
	function automatic logic [12:0] dco_step(input logic [3:0] d, input logic [7:0] s,
		input logic up);
		logic [12:0] r;
		r = {1'b0, d, s};
		if (up) begin
			if (s != STAGE_TOP) begin
				r = {1'b0, d, s + 8'h01};
			end else if (d < DIV_MAX) begin
				r = {1'b0, d + 4'h1, STAGE_BOT};
			end else begin
				r = {1'b1, d, s};
			end
		end else begin
			if (s != STAGE_BOT) begin
				r = {1'b0, d, s - 8'h01};
			end else if (d != RST_DIV) begin
				r = {1'b0, d - 4'h1, STAGE_TOP};
			end else begin
				r = {1'b1, d, s};
			end
		end
		return r;
	endfunction : dco_step

	// Filter outputs change by one count only; divider moves on carry or borrow.
	always_ff @(posedge mclk) begin
		if (reset) begin
			stage_control_q <= RST_STAGE;
			divider_control_q <= RST_DIV;
			limit_q <= 1'b0;
		end else if (step_up ^ step_down) begin
			{limit_q, divider_control_q, stage_control_q} <=
				dco_step(divider_control_q, stage_control_q, step_up);
		end else begin
			limit_q <= 1'b0;
		end
	end

	// Fine adjust: the long ring runs for stage[4:0] of every 32 cycles.
	assign long_ring = phase_q < stage_control_q[4:0];
	assign coarse = RING_MIN + {2'b00, stage_control_q[7:5], 1'b0};

	// Ring length per cycle; long ring cycles use RING_DOUBLED when the coarse code is at its top.
	always_ff @(posedge mclk) begin
		if (reset) begin
			phase_q <= '0;
			ring_stages_q <= RING_MIN;
		end else begin
			phase_q <= phase_q + 5'h01;
			if (!long_ring) begin
				ring_stages_q <= coarse;
			end else if (stage_control_q[7:5] == COARSE_TOP) begin
				ring_stages_q <= RING_DOUBLED;
			end else begin
				ring_stages_q <= coarse + RING_FINE;
			end
		end
	end

endmodule : cmc_dco

// ==== rtl/cmc_ctrl.sv ====
// Clock monitor control, source switching, interrupts and registers.
`timescale 1ns/1ps

// Function
// - Monitor enable sets only with both generators on and both sources stable.
// - Monitor interrupt enable sets only while monitor enable is already set.
// - Monitor flag reads back as bit 6 of the control register.
// - Flag clear needs a prior control read while the flag is set.
// - Later write of zero to the flag clears it; one leaves it.
// - Monitor enable stays set when a source later loses stability.
// - On inactivity both clock switches are forced to the active source.
// - After a forced switch the select bit shows the source in use.
// - Oscillator period follows eight bit stage and four bit divider controls.
// - Loop filter outputs move only by single increments or decrements.
// - Averaged period error falls to the fine step floor.
// - Source switches select the internal clock during reset.
// - Inactive side deselected at once, active side selected two cycles later.
module cmc_ctrl
	import cmc_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata_q,
	// Source status from the activity detectors
	input wire logic int_clock_stable,
	input wire logic ext_clock_stable,
	input wire logic internal_inactive,
	input wire logic external_inactive,
	// Generator enables
	output logic int_gen_on_q,
	output logic ext_gen_on_q,
	output logic slow_external_select_q,
	// Clock switch selects
	output logic osc_use_int_q,
	output logic osc_use_ext_q,
	output logic tb_use_int_q,
	output logic tb_use_ext_q,
	// Oscillator controls
	output logic [7:0] stage_control_q,
	output logic [3:0] divider_control_q,
	output logic [5:0] ring_stages_q,
	// Interrupt
	output logic irq_q
);

	// ==================================================
	// Synchronised status

	logic [3:0] sync_q;
	logic int_stab;
	logic ext_stab;
	logic int_off;
	logic ext_off;
	logic int_off_prev_q;
	logic ext_off_prev_q;
	logic stab_prev_q;

	// Status levels come from other clock domains.
	cmc_sync3 #(
		.W(4)
	) u_sync (
		.mclk(mclk),
		.reset(reset),
		.din({external_inactive, internal_inactive, ext_clock_stable, int_clock_stable}),
		.dout_q(sync_q)
	);

	// A source is only stable while on and active.
	assign int_off = sync_q[2];
	assign ext_off = sync_q[3];
	assign int_stab = sync_q[0] & int_gen_on_q & ~int_off;
	assign ext_stab = sync_q[1] & ext_gen_on_q & ~ext_off;

	// ==================================================
	// Decode

	logic wr_ctrl;
	logic rd_ctrl;
	logic wr_step;
	logic wr_status;
	logic wr_mask;
	logic wr_config;
	logic both_ready;

	// Write and read strobes per register.
	assign wr_ctrl = wr && (addr == OFS_CTRL);
	assign rd_ctrl = rd && (addr == OFS_CTRL);
	assign wr_step = wr && (addr == OFS_STEP);
	assign wr_status = wr && (addr == OFS_STATUS);
	assign wr_mask = wr && (addr == OFS_MASK);
	assign wr_config = wr && (addr == OFS_CONFIG);
	assign both_ready = int_gen_on_q & ext_gen_on_q & int_stab & ext_stab;

	// ==================================================
	// Monitor events and forcing

	logic monitor_enable_q;
	logic monitor_irq_enable_q;
	logic monitor_flag_q;
	logic flag_armed_q;
	logic clock_select_q;
	logic mon_trip;
	logic force_ext;
	logic force_int;

	// A new inactivity edge while monitoring is a trip.
	assign mon_trip = monitor_enable_q &
		((int_off & ~int_off_prev_q) | (ext_off & ~ext_off_prev_q));

	// The monitor forces the switches toward the source that still runs.
	assign force_ext = monitor_enable_q & int_off & ~ext_off;
	assign force_int = monitor_enable_q & ext_off & ~int_off;

	// Edge history of inactivity and stability.
	always_ff @(posedge mclk) begin
		if (reset) begin
			int_off_prev_q <= 1'b0;
			ext_off_prev_q <= 1'b0;
			stab_prev_q <= 1'b0;
		end else begin
			int_off_prev_q <= int_off;
			ext_off_prev_q <= ext_off;
			stab_prev_q <= int_stab & ext_stab;
		end
	end

	// ==================================================
	// Control register

	// Monitor enable: set is gated by readiness, never dropped by hardware.
	always_ff @(posedge mclk) begin
		if (reset) begin
			monitor_enable_q <= 1'b0;
		end else if (wr_ctrl) begin
			if (!wdata[B_MON_EN]) begin
				monitor_enable_q <= 1'b0;
			end else if (both_ready) begin
				monitor_enable_q <= 1'b1;
			end
		end
	end

	// Interrupt enable looks at the monitor enable held before this write.
	always_ff @(posedge mclk) begin
		if (reset) begin
			monitor_irq_enable_q <= 1'b0;
		end else if (wr_ctrl) begin
			monitor_irq_enable_q <= wdata[B_IRQ_EN] & monitor_enable_q;
		end
	end

	// Flag arms on a read that sees it set; a trip wins over a clear.
	always_ff @(posedge mclk) begin
		if (reset) begin
			monitor_flag_q <= 1'b0;
			flag_armed_q <= 1'b0;
		end else if (mon_trip) begin
			monitor_flag_q <= 1'b1;
			flag_armed_q <= flag_armed_q | (rd_ctrl & monitor_flag_q);
		end else if (wr_ctrl && flag_armed_q && !wdata[B_FLAG]) begin
			monitor_flag_q <= 1'b0;
			flag_armed_q <= 1'b0;
		end else if (rd_ctrl && monitor_flag_q) begin
			flag_armed_q <= 1'b1;
		end
	end

	// Select bit: forced by the monitor, otherwise changes only to an on, stable source.
	always_ff @(posedge mclk) begin
		if (reset) begin
			clock_select_q <= 1'b0;
		end else if (force_ext) begin
			clock_select_q <= 1'b1;
		end else if (force_int) begin
			clock_select_q <= 1'b0;
		end else if (wr_ctrl && wdata[B_CSEL] != clock_select_q && int_gen_on_q &&
			ext_gen_on_q && (wdata[B_CSEL] ? ext_stab : int_stab)) begin
			clock_select_q <= wdata[B_CSEL];
		end
	end

	// Generator enables; the source selected before this write cannot be turned off.
	always_ff @(posedge mclk) begin
		if (reset) begin
			int_gen_on_q <= RST_INT_ON;
			ext_gen_on_q <= RST_EXT_ON;
		end else if (wr_ctrl) begin
			int_gen_on_q <= wdata[B_INT_ON] | ~clock_select_q;
			ext_gen_on_q <= wdata[B_EXT_ON] | clock_select_q;
		end
	end

	// Slow external select is plain configuration for the detectors.
	always_ff @(posedge mclk) begin
		if (reset) begin
			slow_external_select_q <= 1'b0;
		end else if (wr_config) begin
			slow_external_select_q <= wdata[B_SLOW_EXT];
		end
	end

	// ==================================================
	// Clock switches (index 0 oscillator output, 1 timebase)

	cmc_sw_t sw_state_q [2];
	logic [1:0] sw_cnt_q [2];
	logic [1:0] sel_ext_q;
	logic [1:0] sel_int_q;
	logic [1:0] sw_tgt;

	// Oscillator follows the select bit, timebase the external enable.
	assign sw_tgt[0] = force_ext | (~force_int & clock_select_q);
	assign sw_tgt[1] = force_ext | (~force_int & ext_gen_on_q);

	// Old side drops at once, new side joins after a hold of two cycles.
	always_ff @(posedge mclk) begin
		if (reset) begin
			for (int i = 0; i < 2; i++) begin
				sw_state_q[i] <= SW_RUN;
				sw_cnt_q[i] <= '0;
				sel_ext_q[i] <= 1'b0;
				sel_int_q[i] <= 1'b1;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				case (sw_state_q[i])
					SW_RUN: begin
						if (sw_tgt[i] != sel_ext_q[i] || !(sel_ext_q[i] | sel_int_q[i])) begin
							sel_ext_q[i] <= 1'b0;
							sel_int_q[i] <= 1'b0;
							sw_cnt_q[i] <= '0;
							sw_state_q[i] <= SW_HOLD;
						end
					end
					SW_HOLD: begin
						if (sw_cnt_q[i] == SW_HOLD_LAST) begin
							sel_ext_q[i] <= sw_tgt[i];
							sel_int_q[i] <= ~sw_tgt[i];
							sw_state_q[i] <= SW_RUN;
						end else begin
							sw_cnt_q[i] <= sw_cnt_q[i] + 2'h1;
						end
					end
					default: begin
						sw_state_q[i] <= SW_RUN;
					end
				endcase
			end
		end
	end

	// Switch selects drive the clock gates directly.
	assign osc_use_ext_q = sel_ext_q[0];
	assign osc_use_int_q = sel_int_q[0];
	assign tb_use_ext_q = sel_ext_q[1];
	assign tb_use_int_q = sel_int_q[1];

	// ==================================================
	// Oscillator control

	logic dco_limit;

	// Step requests come from the step register.
	cmc_dco u_dco (
		.mclk(mclk),
		.reset(reset),
		.step_up(wr_step & wdata[B_STEP_UP]),
		.step_down(wr_step & wdata[B_STEP_DN]),
		.stage_control_q(stage_control_q),
		.divider_control_q(divider_control_q),
		.ring_stages_q(ring_stages_q),
		.limit_q(dco_limit)
	);

	// ==================================================
	// Interrupts

	logic [ST_W-1:0] status_q;
	logic [ST_W-1:0] mask_q;
	logic [ST_W-1:0] events;

	// Events that latch into the status register.
	always_comb begin
		events = '0;
		events[ST_TRIP] = mon_trip;
		events[ST_FORCED] = mon_trip & (force_ext | force_int);
		events[ST_STAB_LOST] = monitor_enable_q & stab_prev_q & ~(int_stab & ext_stab);
		events[ST_LIMIT] = dco_limit;
	end

	// Write one clears; an event in the same cycle wins.
	always_ff @(posedge mclk) begin
		if (reset) begin
			status_q <= '0;
		end else if (wr_status) begin
			status_q <= (status_q & ~wdata[ST_W-1:0]) | events;
		end else begin
			status_q <= status_q | events;
		end
	end

	// Mask register.
	always_ff @(posedge mclk) begin
		if (reset) begin
			mask_q <= RST_MASK;
		end else if (wr_mask) begin
			mask_q <= wdata[ST_W-1:0];
		end
	end

	// Level interrupt from the monitor flag while its interrupt enable is set, or any unmasked status bit.
	always_ff @(posedge mclk) begin
		if (reset) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (monitor_flag_q & monitor_irq_enable_q) | (|(status_q & mask_q));
		end
	end

	// ==================================================
	// Read data

	logic [DATA_W-1:0] ctrl_image;

	// Control register layout as software sees it.
	always_comb begin
		ctrl_image = '0;
		ctrl_image[B_IRQ_EN] = monitor_irq_enable_q;
		ctrl_image[B_FLAG] = monitor_flag_q;
		ctrl_image[B_MON_EN] = monitor_enable_q;
		ctrl_image[B_CSEL] = clock_select_q;
		ctrl_image[B_EXT_ON] = ext_gen_on_q;
		ctrl_image[B_EXT_STAB] = ext_stab;
		ctrl_image[B_INT_ON] = int_gen_on_q;
		ctrl_image[B_INT_STAB] = int_stab;
	end

	// Read data stands for the one cycle after the read strobe.
	always_ff @(posedge mclk) begin
		if (reset || !rd) begin
			rdata_q <= RD_NONE;
		end else if (addr == OFS_CTRL) begin
			rdata_q <= ctrl_image;
		end else if (addr == OFS_STAGE) begin
			rdata_q <= stage_control_q;
		end else if (addr == OFS_DIVIDER) begin
			rdata_q <= {4'h0, divider_control_q};
		end else if (addr == OFS_STEP) begin
			rdata_q <= {2'h0, ring_stages_q};
		end else if (addr == OFS_STATUS) begin
			rdata_q <= {4'h0, status_q};
		end else if (addr == OFS_MASK) begin
			rdata_q <= {4'h0, mask_q};
		end else if (addr == OFS_CONFIG) begin
			rdata_q <= {7'h00, slow_external_select_q};
		end else begin
			rdata_q <= RD_NONE;
		end
	end

endmodule : cmc_ctrl

// ==== bench/cmc_ctrl_props.sv ====
// Concurrent checks on the ports of the clock monitor control block.
`timescale 1ns/1ps

module cmc_ctrl_props
	import cmc_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [DATA_W-1:0] rdata_q,
	// Source status
	input wire logic int_clock_stable,
	input wire logic ext_clock_stable,
	input wire logic internal_inactive,
	input wire logic external_inactive,
	// Generator enables
	input wire logic int_gen_on_q,
	input wire logic ext_gen_on_q,
	input wire logic slow_external_select_q,
	// Clock switch selects
	input wire logic osc_use_int_q,
	input wire logic osc_use_ext_q,
	input wire logic tb_use_int_q,
	input wire logic tb_use_ext_q,
	// Oscillator controls and interrupt
	input wire logic [7:0] stage_control_q,
	input wire logic [3:0] divider_control_q,
	input wire logic [5:0] ring_stages_q,
	input wire logic irq_q
);
	// ==================================================
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	// Read data only stands in the cycle after a read strobe.
	a_read_idle_zero: assert property (!$past(rd) |-> rdata_q == RD_NONE)
		else $error("Read data not zero outside the read answer cycle.");
	a_osc_never_both: assert property (!(osc_use_int_q && osc_use_ext_q))
		else $error("Oscillator switch selects both sources.");
	a_tb_never_both: assert property (!(tb_use_int_q && tb_use_ext_q))
		else $error("Timebase switch selects both sources.");
	a_reset_selects_internal: assert property (disable iff (1'b0) reset |=>
		osc_use_int_q && tb_use_int_q && !osc_use_ext_q && !tb_use_ext_q)
		else $error("Switches not on the internal clock after reset.");
	// Break before make: both selects low for two cycles, then the new side.
	a_osc_switch_hold: assert property ($fell(osc_use_int_q) |-> !osc_use_ext_q
		##1 (!osc_use_int_q && !osc_use_ext_q) ##1 osc_use_ext_q)
		else $error("Oscillator switch hold sequence wrong.");
	a_forced_back_int: assert property ($fell(osc_use_ext_q) |-> ##2 osc_use_int_q)
		else $error("Internal side not selected two cycles after release.");
	a_step_single: assert property ($changed({divider_control_q, stage_control_q}) |->
		({divider_control_q, stage_control_q} - $past({divider_control_q, stage_control_q}))
		inside {12'h001, 12'hFFF})
		else $error("Oscillator control moved by more than one step.");
	a_step_cause: assert property ($changed(stage_control_q) |->
		$past(wr) && $past(addr) == OFS_STEP)
		else $error("Stage control changed without a step write.");
	a_divider_range: assert property (divider_control_q <= DIV_MAX)
		else $error("Divider control above its maximum.");
	a_ring_coarse: assert property (!$past(reset) && !$past(reset, 2) &&
		$stable(stage_control_q) && stage_control_q[4:0] == 5'h00 |->
		ring_stages_q == RING_MIN + {2'h0, stage_control_q[7:5], 1'b0})
		else $error("Ring length does not follow the coarse stage bits.");

	// Main scenarios.
	c_irq_rise: cover property ($rose(irq_q));
	c_to_external: cover property ($rose(osc_use_ext_q));
	c_forced_back: cover property ($fell(osc_use_ext_q));
endmodule : cmc_ctrl_props

bind cmc_ctrl cmc_ctrl_props cmc_ctrl_props_i (.mclk, .reset, .addr, .wdata, .wr, .rd,
	.rdata_q, .int_clock_stable, .ext_clock_stable, .internal_inactive, .external_inactive,
	.int_gen_on_q, .ext_gen_on_q, .slow_external_select_q, .osc_use_int_q, .osc_use_ext_q,
	.tb_use_int_q, .tb_use_ext_q, .stage_control_q, .divider_control_q, .ring_stages_q,
	.irq_q);

// ==== bench/testbench.sv ====
// Self-checking testbench for the clock monitor control block.
`timescale 1ns/1ps

module testbench;
	import cmc_pkg::*;

	// Stimulus and observed ports
	logic mclk, reset, wr, rd, int_clock_stable, ext_clock_stable;
	logic internal_inactive, external_inactive, irq_q, slow_external_select_q;
	logic int_gen_on_q, ext_gen_on_q, osc_use_int_q, osc_use_ext_q, tb_use_int_q, tb_use_ext_q;
	logic [3:0] addr, divider_control_q;
	logic [7:0] wdata, rdata_q, stage_control_q;
	logic [5:0] ring_stages_q;
	int n_mismatch = 0;
	int checks = 0;

	cmc_ctrl cmc_ctrl_i (.mclk, .reset, .addr, .wdata, .wr, .rd, .rdata_q, .int_clock_stable,
		.ext_clock_stable, .internal_inactive, .external_inactive, .int_gen_on_q, .ext_gen_on_q,
		.slow_external_select_q, .osc_use_int_q, .osc_use_ext_q, .tb_use_int_q, .tb_use_ext_q,
		.stage_control_q, .divider_control_q, .ring_stages_q, .irq_q);

	// ==================================================
	// Helpers
	// Compares a seen value with its expectation and counts it.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// Holds the write strobe for n edges, so n equal writes go back to back.
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d, input int n);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		repeat (n) @(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg

	// Reads one register and compares the masked answer.
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(rdata_q & m, exp);
	endtask : rd_chk

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	// ==================================================
	// Clock, watchdog and main sequence
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (5000) @(posedge mclk);
		n_mismatch++;
		wrap_up();
	end

	// Works through reset, monitor enabling, a trip, flag clearing and stepping.
	initial begin
		int i;
		reset = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		int_clock_stable = 1'b1;
		ext_clock_stable = 1'b1;
		internal_inactive = 1'b0;
		external_inactive = 1'b0;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		repeat (6) @(posedge mclk);
		rd_chk(OFS_CTRL, 8'h03, 8'hFF);
		chk({4'h0, osc_use_int_q, osc_use_ext_q, tb_use_int_q, tb_use_ext_q}, 8'h0A);
		rd_chk(4'hF, 8'h00, 8'hFF);
		wr_reg(OFS_CONFIG, 8'h01, 1);
		#1 chk({7'h00, slow_external_select_q}, 8'h01);
		// Monitor enable refused while the external generator was still off.
		wr_reg(OFS_CTRL, 8'h2A, 1);
		repeat (4) @(posedge mclk);
		rd_chk(OFS_CTRL, 8'h0F, 8'hFF);
		chk({6'h00, int_gen_on_q, ext_gen_on_q}, 8'h03);
		// Select the external source first, then enable the monitor, then interrupts.
		wr_reg(OFS_CTRL, 8'h1F, 1);
		wr_reg(OFS_CTRL, 8'hBF, 1);
		rd_chk(OFS_CTRL, 8'h3F, 8'hFF);
		wr_reg(OFS_CTRL, 8'hBF, 1);
		rd_chk(OFS_CTRL, 8'hBF, 8'hFF);
		repeat (4) @(posedge mclk);
		#1 chk({4'h0, osc_use_int_q, osc_use_ext_q, tb_use_int_q, tb_use_ext_q}, 8'h05);
		chk({7'h00, irq_q}, 8'h00);
		// External source goes quiet while monitoring.
		@(posedge mclk);
		external_inactive <= 1'b1;
		for (i = 0; i < 16 && irq_q !== 1'b1; i++) @(posedge mclk);
		#1 chk({7'h00, irq_q}, 8'h01);
		repeat (5) @(posedge mclk);
		#1 chk({4'h0, osc_use_int_q, osc_use_ext_q, tb_use_int_q, tb_use_ext_q}, 8'h0A);
		// Flag survives an unarmed write of zero and a write of one.
		wr_reg(OFS_CTRL, 8'hAB, 1);
		wr_reg(OFS_CTRL, 8'hEB, 1);
		rd_chk(OFS_CTRL, 8'hEB, 8'hFF);
		wr_reg(OFS_CTRL, 8'hAB, 1);
		rd_chk(OFS_CTRL, 8'hAB, 8'hFF);
		repeat (2) @(posedge mclk);
		#1 chk({7'h00, irq_q}, 8'h00);
		// Status events raise the interrupt only through the mask.
		rd_chk(OFS_STATUS, 8'h03, 8'h03);
		wr_reg(OFS_MASK, 8'h01, 1);
		repeat (2) @(posedge mclk);
		#1 chk({7'h00, irq_q}, 8'h01);
		wr_reg(OFS_STATUS, 8'h0F, 1);
		repeat (2) @(posedge mclk);
		#1 chk({7'h00, irq_q}, 8'h00);
		rd_chk(OFS_STATUS, 8'h00, 8'h03);
		wr_reg(OFS_MASK, 8'h00, 1);
		wr_reg(OFS_CTRL, 8'h0B, 1);
		rd_chk(OFS_CTRL, 8'h0B, 8'hFF);
		@(posedge mclk);
		external_inactive <= 1'b0;
		// Oscillator stepping, a no-step write, the lower limit and a carry.
		wr_reg(OFS_STEP, 8'h01, 1);
		rd_chk(OFS_STAGE, 8'h81, 8'hFF);
		wr_reg(OFS_STEP, 8'h03, 1);
		rd_chk(OFS_STAGE, 8'h81, 8'hFF);
		wr_reg(OFS_STEP, 8'h02, 130);
		rd_chk(OFS_STAGE, 8'h00, 8'hFF);
		rd_chk(OFS_DIVIDER, 8'h00, 8'hFF);
		rd_chk(OFS_STATUS, 8'h08, 8'h08);
		rd_chk(OFS_STEP, 8'h11, 8'hFF);
		wr_reg(OFS_STEP, 8'h01, 256);
		rd_chk(OFS_STAGE, 8'h00, 8'hFF);
		rd_chk(OFS_DIVIDER, 8'h01, 8'hFF);
		#1 chk({divider_control_q, stage_control_q[7:4]}, 8'h10);
		wrap_up();
	end
endmodule : testbench
